// file: imuhs_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * imu health, self-test and configuration block.
 * assumes a 32-bit axi4-lite slave with word-aligned registers.
 */
`ifndef IMUHS_REGS_SVH
`define IMUHS_REGS_SVH

// register byte offsets
`define IMUHS_CTRL_OFS        8'h00
`define IMUHS_STATUS_OFS      8'h04
`define IMUHS_ODR_DIV_OFS     8'h08
`define IMUHS_SAMPLE_OFS      8'h0c
`define IMUHS_HEALTH_SET_OFS  8'h10
`define IMUHS_SELFTEST_LO_OFS 8'h14
`define IMUHS_SELFTEST_HI_OFS 8'h18
`define IMUHS_TIME_SET_OFS    8'h1c
`define IMUHS_TIME_NOW_OFS    8'h20
`define IMUHS_PERSIST_OFS     8'h24
`define IMUHS_NV_COUNT_OFS    8'h28
`define IMUHS_WR_ACK_OFS      8'h2c

// control register fields
`define IMUHS_CTRL_STREAM_BIT   0
`define IMUHS_CTRL_TIME_ARM_BIT 1

// status register fields
`define IMUHS_ST_AVAIL_BIT  0
`define IMUHS_ST_STREAM_BIT 1
`define IMUHS_ST_ARMED_BIT  2
`define IMUHS_ST_LIMIT_BIT  3

// health code widths and codes
`define IMUHS_ACC_HEALTH_W  3
`define IMUHS_GYR_HEALTH_W  5
`define IMUHS_ACC_FAIL      3'h7
`define IMUHS_GYR_FAIL      5'h1f
`define IMUHS_HEALTH_OK     5'h00
`define IMUHS_ST_PASS       8'h03

// write acknowledge codes
`define IMUHS_ACK_OK        8'h00
`define IMUHS_ACK_NV_LIMIT  8'h01
`define IMUHS_ACK_BUSY      8'h02

// timing
`define IMUHS_CLK_HZ        25000000
`define IMUHS_ODR_MAX_HZ    1000
`define IMUHS_ODR_MIN_HZ    10
`define IMUHS_NV_LIMIT      10000
`define IMUHS_ODR_DIV_RST   16'h0001

`endif

// file: imuhs_pkg.sv
/*
 * types of the imu health, self-test and configuration block.
 * assumes imuhs_regs.svh for numbers.
 */
package imuhs_pkg;
	typedef enum logic [1:0] {
		IMUHS_AXI_OKAY   = 2'b00,
		IMUHS_AXI_SLVERR = 2'b10
	} imuhs_resp_type;

	typedef enum logic [0:0] {
		IMUHS_MODE_CMD    = 1'b0,
		IMUHS_MODE_STREAM = 1'b1
	} imuhs_mode_type;
endpackage : imuhs_pkg

// file: imuhs_core.sv
/*
 * imu health, self-test and configuration block: health codes, self-test
 * bytes, sample-available output, second-pulse time alignment, persistent
 * settings with a saturating write counter, all behind an axi4-lite slave.
 * assumes aclk at 25 mhz; second_pulse_input and reset_pin are asynchronous.
 */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
// What this block does
// - accelerometer samples carry three-bit health, gyroscope samples five-bit health.
// - health zero means fully trustworthy, also after lossless recovery.
// - accelerometer health all-ones means output untrustworthy.
// - gyroscope health all-ones means output untrustworthy.
// - other health codes mean partly trustworthy, early warning.
// - monitor quality, attempt recovery, update health codes.
// - self-test gives six bytes; pass code per byte, else failure.
// - sample-available output rises when a new sample set exists.
// - sample rate programmable from one thousand to ten per second.
// - low-to-high edge on host reset pin resets the device.
// - set-time value takes effect at the next second pulse.
// - timestamp kept as unix seconds count.
// - persist write copies eligible settings into non-volatile store.
// - non-volatile writes counted in readable register; limit ten thousand; code blocks stores only once the count exceeds it, after 10001.
// - over-limit makes register-write acknowledge carry an error code.
// - device is slave only, never initiates transfers.
// - register read and write accepted only in command mode; stream mode still allows ctrl/time-set writes, status/sample/time-now reads.
`timescale 1ns/10ps
`include "imuhs_regs.svh"

module imuhs_core #(
	parameter int ODR_DIV_MAX = (`IMUHS_CLK_HZ / `IMUHS_ODR_MIN_HZ) / (`IMUHS_CLK_HZ / `IMUHS_ODR_MAX_HZ),
	parameter int BASE_TICKS  = `IMUHS_CLK_HZ / `IMUHS_ODR_MAX_HZ,
	parameter int SEC_TICKS   = `IMUHS_CLK_HZ
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output imuhs_pkg::imuhs_resp_type    s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output imuhs_pkg::imuhs_resp_type    s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    second_pulse_input,
	input  wire logic                    reset_pin,
	input  wire logic [7:0]              monitor_degrade,
	input  wire logic [47:0]             selftest_bytes,
	output logic                         sample_available_out,
	output logic [2:0]                   acc_health,
	output logic [4:0]                   gyr_health,
	output logic [31:0]                  nv_store_data,
	output logic                         nv_store_we
);
	import imuhs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// synchronisers and edge detection
	logic [1:0]  pps_sync;
	logic [1:0]  rst_sync;
	logic        pps_last;
	logic        rst_last;
	logic        pps_rise;
	logic        pin_reset;
	logic        srst;

	// two flops per async input, then an edge register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pps_sync <= 2'h0;
			rst_sync <= 2'h3;
			pps_last <= 1'b0;
			rst_last <= 1'b1;
		end else begin
			pps_sync <= {pps_sync[0], second_pulse_input};
			rst_sync <= {rst_sync[0], reset_pin};
			pps_last <= pps_sync[1];
			rst_last <= rst_sync[1];
		end
	end
	assign pps_rise  = pps_sync[1] & ~pps_last;
	assign pin_reset = rst_sync[1] & ~rst_last;
	assign srst      = ~aresetn | pin_reset;

	////////////////////////////////////////////////////////////////////////////
	// registers written by software
	imuhs_mode_type mode;
	logic        time_armed;
	logic [15:0] odr_div;
	logic [7:0]  health_force;
	logic [31:0] time_set;
	logic [31:0] time_now;
	logic [13:0] nv_count;
	logic [7:0]  wr_ack;
	logic        nv_over;

	// axi write channel state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic        wr_go;
	logic        wr_cfg_ok;
	imuhs_resp_type next_bresp;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_go   = aw_held & w_held & ~s_axi_bvalid;
	assign nv_over = (nv_count > 14'(`IMUHS_NV_LIMIT));

	// address and data taken in either order, answer follows both
	always_ff @(posedge aclk) begin
		if (srst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= IMUHS_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= next_bresp;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// decode: stream control and time always, odr, health and persist only in command mode, others refused
	always_comb begin
		wr_cfg_ok  = 1'b0;
		next_bresp = IMUHS_AXI_OKAY;
		case (aw_addr)
			`IMUHS_CTRL_OFS, `IMUHS_TIME_SET_OFS: wr_cfg_ok = 1'b0;
			`IMUHS_ODR_DIV_OFS, `IMUHS_HEALTH_SET_OFS, `IMUHS_PERSIST_OFS: begin
				wr_cfg_ok  = (mode == IMUHS_MODE_CMD);
				next_bresp = wr_cfg_ok ? IMUHS_AXI_OKAY : IMUHS_AXI_SLVERR;
			end
			default: next_bresp = IMUHS_AXI_SLVERR;
		endcase
	end

	// configuration and acknowledge code
	always_ff @(posedge aclk) begin
		if (srst) begin
			mode         <= IMUHS_MODE_CMD;
			odr_div      <= `IMUHS_ODR_DIV_RST;
			health_force <= 8'h00;
			time_set     <= 32'h0;
			wr_ack       <= `IMUHS_ACK_OK;
		end else if (wr_go) begin
			if (aw_addr == `IMUHS_CTRL_OFS && s_axi_wstrb[0])
				mode <= imuhs_mode_type'(w_data[`IMUHS_CTRL_STREAM_BIT]);
			if (aw_addr == `IMUHS_TIME_SET_OFS)
				time_set <= w_data;
			if (wr_cfg_ok && aw_addr == `IMUHS_ODR_DIV_OFS) begin
				// clamp keeps the rate between 1000 and 10 per second
				if (w_data[15:0] == 16'h0)
					odr_div <= 16'h0001;
				else if (w_data[15:0] > 16'(ODR_DIV_MAX))
					odr_div <= 16'(ODR_DIV_MAX);
				else
					odr_div <= w_data[15:0];
			end
			if (wr_cfg_ok && aw_addr == `IMUHS_HEALTH_SET_OFS)
				health_force <= w_data[7:0];
			if (aw_addr == `IMUHS_ODR_DIV_OFS || aw_addr == `IMUHS_HEALTH_SET_OFS ||
			    aw_addr == `IMUHS_PERSIST_OFS)
				wr_ack <= !wr_cfg_ok ? `IMUHS_ACK_BUSY :
					nv_over ? `IMUHS_ACK_NV_LIMIT : `IMUHS_ACK_OK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// persistent store and saturating write counter
	always_ff @(posedge aclk) begin
		if (srst) begin
			nv_store_we   <= 1'b0;
			nv_store_data <= 32'h0;
		end else begin
			nv_store_we <= 1'b0;
			if (wr_go && wr_cfg_ok && aw_addr == `IMUHS_PERSIST_OFS && !nv_over) begin
				nv_store_we   <= 1'b1;
				nv_store_data <= {8'h00, health_force, odr_div};
			end
		end
	end

	// counter is lifetime state: only the bus reset clears it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			nv_count <= 14'h0;
		else if (nv_store_we && nv_count != 14'h3fff)
			nv_count <= nv_count + 14'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// sample timing: 1 ms base tick divided by odr_div
	logic [$clog2(BASE_TICKS)-1:0] base_cnt;
	logic [15:0] odr_cnt;
	logic        sample_tick;
	logic        read_sample;

	always_ff @(posedge aclk) begin
		if (srst) begin
			base_cnt <= '0;
			odr_cnt  <= 16'h0;
		end else if (base_cnt == ($clog2(BASE_TICKS))'(BASE_TICKS - 1)) begin
			base_cnt <= '0;
			odr_cnt  <= (odr_cnt + 16'h1 >= odr_div) ? 16'h0 : odr_cnt + 16'h1;
		end else begin
			base_cnt <= base_cnt + 1'b1;
		end
	end
	assign sample_tick = (base_cnt == ($clog2(BASE_TICKS))'(BASE_TICKS - 1)) &&
		(odr_cnt + 16'h1 >= odr_div);

	////////////////////////////////////////////////////////////////////////////
	// health codes: monitor degradation, recover, latch per sample
	logic [2:0] next_acc;
	logic [4:0] next_gyr;

	// bits 2:0 acc, 7:3 gyro, each set bit a failed redundant path
	always_comb begin
		next_acc = monitor_degrade[2:0] | health_force[2:0];
		next_gyr = monitor_degrade[7:3] | health_force[7:3];
		if (next_acc == 3'h0)
			next_acc = 3'(`IMUHS_HEALTH_OK);
		if (next_gyr == 5'h0)
			next_gyr = 5'(`IMUHS_HEALTH_OK);
		if (&monitor_degrade[2:0])
			next_acc = `IMUHS_ACC_FAIL;
		if (&monitor_degrade[7:3])
			next_gyr = `IMUHS_GYR_FAIL;
	end

	always_ff @(posedge aclk) begin
		if (srst) begin
			acc_health <= 3'h0;
			gyr_health <= 5'h0;
		end else if (sample_tick) begin
			acc_health <= next_acc;
			gyr_health <= next_gyr;
		end
	end

	// data-ready: set wins over the read that clears it
	assign read_sample = s_axi_arvalid && s_axi_arready && s_axi_araddr == `IMUHS_SAMPLE_OFS;
	always_ff @(posedge aclk) begin
		if (srst)
			sample_available_out <= 1'b0;
		else if (sample_tick)
			sample_available_out <= 1'b1;
		else if (read_sample)
			sample_available_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// unix seconds: free-running second count, aligned on the second pulse
	logic [$clog2(SEC_TICKS)-1:0] sec_cnt;
	always_ff @(posedge aclk) begin
		if (srst) begin
			sec_cnt    <= '0;
			time_now   <= 32'h0;
			time_armed <= 1'b0;
		end else begin
			if (time_armed && pps_rise) begin
				time_now   <= time_set;
				sec_cnt    <= '0;
				time_armed <= 1'b0;
			end else if (sec_cnt == ($clog2(SEC_TICKS))'(SEC_TICKS - 1)) begin
				sec_cnt  <= '0;
				time_now <= time_now + 32'h1;
			end else begin
				sec_cnt <= sec_cnt + 1'b1;
			end
			if (wr_go && aw_addr == `IMUHS_TIME_SET_OFS)
				time_armed <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel
	logic [31:0] next_rdata;
	logic        rd_ok;
	always_comb begin
		next_rdata = 32'h0;
		rd_ok      = 1'b1;
		case (s_axi_araddr)
			`IMUHS_CTRL_OFS:        next_rdata = {30'h0, time_armed, mode};
			`IMUHS_STATUS_OFS:      next_rdata = {28'h0, nv_over, time_armed, mode,
				sample_available_out};
			`IMUHS_ODR_DIV_OFS:     next_rdata = {16'h0, odr_div};
			`IMUHS_SAMPLE_OFS:      next_rdata = {16'h0, gyr_health, acc_health, 8'h00};
			`IMUHS_HEALTH_SET_OFS:  next_rdata = {24'h0, health_force};
			`IMUHS_SELFTEST_LO_OFS: next_rdata = selftest_bytes[31:0];
			`IMUHS_SELFTEST_HI_OFS: next_rdata = {15'h0,
				selftest_bytes == {6{`IMUHS_ST_PASS}}, selftest_bytes[47:32]};
			`IMUHS_TIME_SET_OFS:    next_rdata = time_set;
			`IMUHS_TIME_NOW_OFS:    next_rdata = time_now;
			`IMUHS_NV_COUNT_OFS:    next_rdata = {18'h0, nv_count};
			`IMUHS_WR_ACK_OFS:      next_rdata = {24'h0, wr_ack};
			default:                rd_ok = 1'b0;
		endcase
		if (mode == IMUHS_MODE_STREAM && s_axi_araddr != `IMUHS_SAMPLE_OFS &&
		    s_axi_araddr != `IMUHS_STATUS_OFS && s_axi_araddr != `IMUHS_TIME_NOW_OFS) begin
			rd_ok      = 1'b0;
			next_rdata = 32'h0;
		end
	end

	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= IMUHS_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= rd_ok ? IMUHS_AXI_OKAY : IMUHS_AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : imuhs_core

// file: imuhs_host_model.sv
/* host pin model: drives the second pulse and the reset pin.
 assumes the bench requests each pulse on a fire input. */
`timescale 1ns/10ps
module imuhs_host_model (
	input  wire logic fire_pulse,
	input  wire logic fire_reset,
	output logic      second_pulse_input,
	output logic      reset_pin
);
	// the only host pin driver, one serial path in use
	initial begin
		second_pulse_input = 1'b0;
		reset_pin = 1'b1;
	end
	// one 160 ns pulse per request, low otherwise
	always @(posedge fire_pulse) begin
		second_pulse_input = 1'b1;
		#160;
		second_pulse_input = 1'b0;
	end
	// pin low for 1 us, the rising edge resets
	always @(posedge fire_reset) begin
		reset_pin = 1'b0;
		#1000;
		reset_pin = 1'b1;
	end
endmodule : imuhs_host_model

// file: imuhs_core_assertions.sv
/* checker of imuhs_core handshakes, store pulse and reset.
 assumes binding to imuhs_core, sees its ports only. */
`timescale 1ns/10ps
module imuhs_core_checker (
	input wire logic                      aclk,
	input wire logic                      aresetn,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic                      s_axi_wvalid,
	input wire logic                      s_axi_wready,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire imuhs_pkg::imuhs_resp_type s_axi_bresp,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic                      sample_available_out,
	input wire logic                      nv_store_we
);
	import imuhs_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	////////////////////////////////////////////////////////////////
	a_write_answer: assert property (disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write answer");
	a_read_answer: assert property (disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	a_bresp_hold: assert property (disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_hold: assert property (disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_refuse: assert property (disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_write_refuse: assert property (disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	a_store_pulse: assert property (disable iff (!aresetn)
		nv_store_we |=> !nv_store_we) else $error("store strobe too long");
	a_reset_quiet: assert property (!aresetn |=> !s_axi_bvalid && !s_axi_rvalid
		&& !nv_store_we && !sample_available_out) else $error("outputs live in reset");
endmodule : imuhs_core_checker
bind imuhs_core imuhs_core_checker chk (
	.aclk                 (aclk),
	.aresetn              (aresetn),
	.s_axi_awvalid        (s_axi_awvalid),
	.s_axi_awready        (s_axi_awready),
	.s_axi_wvalid         (s_axi_wvalid),
	.s_axi_wready         (s_axi_wready),
	.s_axi_bvalid         (s_axi_bvalid),
	.s_axi_bready         (s_axi_bready),
	.s_axi_bresp          (s_axi_bresp),
	.s_axi_arvalid        (s_axi_arvalid),
	.s_axi_arready        (s_axi_arready),
	.s_axi_rvalid         (s_axi_rvalid),
	.s_axi_rready         (s_axi_rready),
	.s_axi_rdata          (s_axi_rdata),
	.sample_available_out (sample_available_out),
	.nv_store_we          (nv_store_we)
);

// file: test_imuhs_core.sv
/* bench of imuhs_core: axi4-lite register tasks and directed tests.
 assumes BASE_TICKS 10 and SEC_TICKS 50 to keep the run short. */
`timescale 1ns/10ps
`include "imuhs_regs.svh"
module test_imuhs_core;
	import imuhs_pkg::*;
	logic           aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic           s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic           s_axi_bvalid, s_axi_arready, s_axi_rvalid, nv_store_we;
	logic           second_pulse_input, reset_pin, sample_available_out;
	logic           fire_pulse, fire_reset, prev_av;
	logic [7:0]     s_axi_awaddr, s_axi_araddr, monitor_degrade;
	logic [31:0]    s_axi_wdata, s_axi_rdata, nv_store_data, d, last_nv;
	logic [3:0]     s_axi_wstrb;
	logic [47:0]    selftest_bytes;
	logic [2:0]     acc_health;
	logic [4:0]     gyr_health;
	imuhs_resp_type s_axi_bresp, s_axi_rresp, r;
	int             fail_count = 0, n_checks = 0, cyc = 0, last_rise = 0, gap = 0;
	imuhs_core #(.BASE_TICKS(10), .SEC_TICKS(50)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .second_pulse_input(second_pulse_input),
		.reset_pin(reset_pin), .monitor_degrade(monitor_degrade),
		.selftest_bytes(selftest_bytes), .sample_available_out(sample_available_out),
		.acc_health(acc_health), .gyr_health(gyr_health),
		.nv_store_data(nv_store_data), .nv_store_we(nv_store_we)
	);
	imuhs_host_model host (
		.fire_pulse(fire_pulse), .fire_reset(fire_reset),
		.second_pulse_input(second_pulse_input), .reset_pin(reset_pin)
	);
	////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task chkr(input string nm, input imuhs_resp_type e, input imuhs_resp_type g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chkr
	// write: both channels offered, each released at its own handshake
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ah, wh, bh;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge aclk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	// read: address held until taken, data taken with rvalid
	task rd(input logic [7:0] a);
		logic ah, rh;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge aclk);
			ah = s_axi_arvalid & s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	task wait_avail;
		@(negedge aclk);
		while (sample_available_out !== 1'b1) @(negedge aclk);
	endtask : wait_avail
	////////////////////////////////////////////////////////////////
	// clock, cycle count and hang limit
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			stop_test;
		end
	end
	// sample spacing and stored word monitor
	always @(negedge aclk) begin
		if (sample_available_out === 1'b1 && prev_av === 1'b0) begin
			gap = cyc - last_rise;
			last_rise = cyc;
		end
		prev_av = sample_available_out;
		if (nv_store_we === 1'b1) last_nv = nv_store_data;
	end
	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, fire_pulse, fire_reset, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, monitor_degrade} = '0;
		s_axi_wstrb = 4'hf;
		selftest_bytes = {6{`IMUHS_ST_PASS}};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`IMUHS_CTRL_OFS); chk("ctrl", 0, d);
		rd(`IMUHS_NV_COUNT_OFS); chk("nv count", 0, d);
		rd(8'h30); chkr("unmapped", IMUHS_AXI_SLVERR, r);
		$display("test reset done");
		repeat (25) @(posedge aclk);
		chk("acc ok", 0, acc_health);
		monitor_degrade <= 8'hff;
		repeat (25) @(posedge aclk);
		chk("acc fail", `IMUHS_ACC_FAIL, acc_health);
		chk("gyr fail", `IMUHS_GYR_FAIL, gyr_health);
		rd(`IMUHS_SAMPLE_OFS); chk("sample health", 8'hff, d[15:8]);
		monitor_degrade <= 8'h09;
		repeat (25) @(posedge aclk);
		chk("acc part", 1, acc_health != 0 && acc_health != 7);
		chk("gyr part", 1, gyr_health != 0 && gyr_health != 31);
		monitor_degrade <= 8'h00;
		repeat (25) @(posedge aclk);
		chk("gyr back", 0, gyr_health);
		$display("test health done");
		wr(`IMUHS_ODR_DIV_OFS, 0); rd(`IMUHS_ODR_DIV_OFS); chk("odr min", 1, d);
		wr(`IMUHS_ODR_DIV_OFS, 'hfff); rd(`IMUHS_ODR_DIV_OFS); chk("odr max", 100, d);
		wait_avail;
		rd(`IMUHS_SAMPLE_OFS);
		@(negedge aclk); chk("avail clear", 0, sample_available_out);
		wait_avail;
		rd(`IMUHS_SAMPLE_OFS);
		wait_avail;
		@(posedge aclk);
		chk("sample gap", 1000, gap);
		$display("test rate done");
		rd(`IMUHS_SELFTEST_LO_OFS); chk("st lo", 32'h03030303, d);
		rd(`IMUHS_SELFTEST_HI_OFS); chk("st hi", 32'h10303, d[16:0]);
		selftest_bytes[39:32] <= 8'h02;
		rd(`IMUHS_SELFTEST_HI_OFS); chk("st fail", 32'h00302, d[16:0]);
		$display("test selftest done");
		wr(`IMUHS_TIME_SET_OFS, 32'h5a5a0001);
		fire_pulse <= 1'b1;
		repeat (8) @(posedge aclk);
		fire_pulse <= 1'b0;
		rd(`IMUHS_TIME_NOW_OFS); chk("time load", 32'h5a5a0001, d);
		repeat (50) @(posedge aclk);
		rd(`IMUHS_TIME_NOW_OFS); chk("time sec", 32'h5a5a0002, d);
		$display("test time done");
		wr(`IMUHS_CTRL_OFS, 1); rd(`IMUHS_STATUS_OFS); chk("stream", 1, d[1]);
		wr(`IMUHS_ODR_DIV_OFS, 5); chkr("stream wr", IMUHS_AXI_SLVERR, r);
		rd(`IMUHS_CTRL_OFS); chkr("stream rd", IMUHS_AXI_SLVERR, r);
		wr(`IMUHS_CTRL_OFS, 0); rd(`IMUHS_ODR_DIV_OFS); chk("odr kept", 100, d);
		rd(`IMUHS_WR_ACK_OFS); chk("ack busy", `IMUHS_ACK_BUSY, d);
		$display("test stream done");
		wr(`IMUHS_PERSIST_OFS, 1); chk("store", 32'h64, last_nv);
		repeat (10000) wr(`IMUHS_PERSIST_OFS, 1);
		rd(`IMUHS_NV_COUNT_OFS); chk("nv 10001", 10001, d);
		wr(`IMUHS_PERSIST_OFS, 1);
		rd(`IMUHS_WR_ACK_OFS); chk("ack limit", `IMUHS_ACK_NV_LIMIT, d);
		rd(`IMUHS_NV_COUNT_OFS); chk("nv held", 10001, d);
		rd(`IMUHS_STATUS_OFS); chk("nv over", 1, d[3]);
		$display("test persist done");
		fire_reset <= 1'b1;
		repeat (40) @(posedge aclk);
		rd(`IMUHS_ODR_DIV_OFS); chk("pin reset", 1, d);
		rd(`IMUHS_NV_COUNT_OFS); chk("nv kept", 10001, d);
		$display("test reset pin done");
		stop_test;
	end
endmodule : test_imuhs_core
